// >>> core/field_pkg.sv
// constants and types shared by the field sensor readout
package field_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SAMPLE_PERIOD_NS = 31_250_000;
  localparam int SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BIT_PERIOD_NS = 1000;
  localparam int BIT_CYC = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ADC_W = 12;
  localparam int RANGE_W = 3;
  localparam int NUM_RANGES = 8;
  localparam int CMD_W = 12;
  localparam int FIFO_DEPTH = 8;
  localparam logic [RANGE_W-1:0] RANGE_RST = 3'h7;
  localparam logic [RANGE_W-1:0] RANGE_MAX = 3'h7;
  localparam logic [RANGE_W-1:0] RANGE_MIN = 3'h0;
  localparam logic [ADC_W-1:0] UP_LEVEL = 12'h07c0;
  localparam logic [ADC_W-1:0] DOWN_LEVEL = 12'h01c0;
  localparam logic [3:0] OP_AUTO = 4'h1;
  localparam logic [3:0] OP_HOLD = 4'h2;
  localparam logic [3:0] OP_FLIP = 4'h3;
  // full scale in nT and step size in units of 1e-4 nT, index = range
  localparam int FULL_SCALE_NT [NUM_RANGES] =
    '{4, 16, 64, 256, 1024, 4096, 16384, 65536};
  localparam int STEP_E4_NT [NUM_RANGES] =
    '{10, 40, 160, 625, 2500, 10000, 40000, 160000};

  typedef struct packed {
    logic flip;
    logic [RANGE_W-1:0] range;
    logic [ADC_W-1:0] x;
    logic [ADC_W-1:0] y;
    logic [ADC_W-1:0] z;
  } sample_word_t;

  localparam int WORD_BITS = $bits(sample_word_t);
  localparam int FRAME_CYC = WORD_BITS * BIT_CYC;

  typedef struct packed {
    logic [3:0] op;
    logic [4:0] spare;
    logic [RANGE_W-1:0] arg;
  } cmd_word_t;

  // magnitude of a two's complement converter code
  function automatic logic [ADC_W-1:0] field_sensor_instrument(input logic [ADC_W-1:0] v);
    field_sensor_instrument = v[ADC_W-1] ? ADC_W'(~v + 1'b1) : v;
  endfunction : field_sensor_instrument
endpackage : field_pkg

// >>> core/sample_fifo.sv
// small valid/ready fifo for sample words
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = (wr_r != rd_r);
  assign out_data_o = mem_r[rd_r[AW-1:0]];

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) mem_r[wr_r[AW-1:0]] <= in_data_i;
  end
endmodule : sample_fifo
`default_nettype wire

// >>> core/field_readout.sv
// range control, sampling and serial streaming of the field sensor instrument
`timescale 1ns/1ns
`default_nettype none
module field_readout
  import field_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  output logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [ADC_W-1:0] adc_x_i,
  input wire logic [ADC_W-1:0] adc_y_i,
  input wire logic [ADC_W-1:0] adc_z_i,
  output logic [RANGE_W-1:0] range_sel_o,
  output logic flip_en_o,
  input wire logic cmd_clk_i,
  input wire logic cmd_data_i,
  input wire logic cmd_frame_i,
  output logic link_data_o,
  output logic link_frame_o
);
  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_CONV = 3'b010,
    CAP_PUSH = 3'b100
  } cap_state_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

  // sample timer
  logic [$clog2(SAMPLE_CYCLES)-1:0] tick_cnt_r;
  logic [$clog2(BIT_CYC)-1:0] bit_div_r;
  wire tick = (tick_cnt_r == '0);
  wire bit_en = (bit_div_r == '0);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      tick_cnt_r <= '0;
      bit_div_r <= '0;
    end else begin
      tick_cnt_r <= tick ? $bits(tick_cnt_r)'(SAMPLE_CYCLES - 1)
                         : tick_cnt_r - 1'b1;
      bit_div_r <= bit_en ? $bits(bit_div_r)'(BIT_CYC - 1)
                          : bit_div_r - 1'b1;
    end
  end

  // command pins: three flops, a change counts when stages two and three agree
  logic [2:0] sck_q_r, sda_q_r, sfr_q_r;
  logic sck_s_r, sda_s_r, sfr_s_r;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sck_q_r <= '0;
      sda_q_r <= '0;
      sfr_q_r <= '0;
      sck_s_r <= 1'b0;
      sda_s_r <= 1'b0;
      sfr_s_r <= 1'b0;
    end else begin
      sck_q_r <= {sck_q_r[1:0], cmd_clk_i};
      sda_q_r <= {sda_q_r[1:0], cmd_data_i};
      sfr_q_r <= {sfr_q_r[1:0], cmd_frame_i};
      if (sck_q_r[1] == sck_q_r[2]) sck_s_r <= sck_q_r[2];
      if (sda_q_r[1] == sda_q_r[2]) sda_s_r <= sda_q_r[2];
      if (sfr_q_r[1] == sfr_q_r[2]) sfr_s_r <= sfr_q_r[2];
    end
  end
  wire sck_next = (sck_q_r[1] == sck_q_r[2]) ? sck_q_r[2] : sck_s_r;
  wire sfr_next = (sfr_q_r[1] == sfr_q_r[2]) ? sfr_q_r[2] : sfr_s_r;
  wire sck_rise = sck_next && !sck_s_r && sfr_s_r;
  wire frame_end = sfr_s_r && !sfr_next;

  // twelve-bit serial command, msb first, taken when the frame closes
  logic [CMD_W-1:0] cmd_sh_r;
  logic [3:0] cmd_cnt_r;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cmd_sh_r <= '0;
      cmd_cnt_r <= '0;
    end else if (frame_end) begin
      cmd_cnt_r <= '0;
    end else if (sck_rise) begin
      cmd_sh_r <= {cmd_sh_r[CMD_W-2:0], sda_s_r};
      if (cmd_cnt_r != 4'(CMD_W + 1)) cmd_cnt_r <= cmd_cnt_r + 1'b1;
    end
  end
  // a short or long frame is dropped: a garbled word must not move the range
  wire cmd_done = frame_end && (cmd_cnt_r == 4'(CMD_W));
  cmd_word_t cmd;
  assign cmd = cmd_sh_r;

  // capture and range control
  cap_state_t cap_r;
  logic auto_r;
  logic flip_r;
  logic [RANGE_W-1:0] range_r;
  sample_word_t word_r;
  logic push_valid;
  logic push_ready;
  assign push_valid = (cap_r == CAP_PUSH);

  wire [ADC_W-1:0] mx = field_sensor_instrument(adc_x_i);
  wire [ADC_W-1:0] my = field_sensor_instrument(adc_y_i);
  wire [ADC_W-1:0] mz = field_sensor_instrument(adc_z_i);
  wire over = (mx > UP_LEVEL) || (my > UP_LEVEL) || (mz > UP_LEVEL);
  wire under = (mx < DOWN_LEVEL) && (my < DOWN_LEVEL) && (mz < DOWN_LEVEL);
  wire take = (cap_r == CAP_CONV) && adc_done_i;
  wire go_up = take && auto_r && over && (range_r != RANGE_MAX);
  wire go_down = take && auto_r && under && (range_r != RANGE_MIN);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      auto_r <= 1'b1;
      flip_r <= 1'b0;
      range_r <= RANGE_RST;
    end else if (cmd_done && cmd.op == OP_HOLD) begin
      auto_r <= 1'b0;
      range_r <= cmd.arg;
    end else if (cmd_done && cmd.op == OP_AUTO) begin
      auto_r <= 1'b1;
    end else if (cmd_done && cmd.op == OP_FLIP) begin
      flip_r <= cmd.arg[0];
    end else if (go_up) begin
      // step up on a strong field
      range_r <= range_r + 1'b1;
    end else if (go_down) begin
      // step down, never below the most sensitive range
      range_r <= range_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cap_r <= CAP_IDLE;
      adc_start_o <= 1'b0;
      word_r <= '0;
    end else begin
      adc_start_o <= tick && (cap_r == CAP_IDLE);
      case (cap_r)
        CAP_IDLE: if (tick) cap_r <= CAP_CONV;
        CAP_CONV: if (adc_done_i) begin
          // range tagged with the codes it scaled
          word_r <= '{flip: flip_r, range: range_r,
                      x: adc_x_i, y: adc_y_i, z: adc_z_i};
          cap_r <= CAP_PUSH;
        end
        CAP_PUSH: if (push_ready) cap_r <= CAP_IDLE;
        default: cap_r <= CAP_IDLE;
      endcase
    end
  end

  // only a small rate-matching queue; at 32 Hz it never fills
  logic pop_valid;
  logic pop_ready;
  logic [WORD_BITS-1:0] pop_data;
  sample_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(word_r),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_data)
  );

  // serializer, 40 bits msb first, no handshake
  tx_state_t tx_r;
  logic [WORD_BITS-1:0] tx_sh_r;
  logic [5:0] tx_cnt_r;
  assign pop_ready = bit_en && (tx_r == TX_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      tx_r <= TX_IDLE;
      tx_sh_r <= '0;
      tx_cnt_r <= '0;
      link_data_o <= 1'b0;
      link_frame_o <= 1'b0;
    end else if (bit_en) begin
      case (tx_r)
        TX_IDLE: if (pop_valid) begin
          tx_sh_r <= {pop_data[WORD_BITS-2:0], 1'b0};
          link_data_o <= pop_data[WORD_BITS-1];
          link_frame_o <= 1'b1;
          tx_cnt_r <= '0;
          tx_r <= TX_SHIFT;
        end
        TX_SHIFT: if (tx_cnt_r == 6'(WORD_BITS - 1)) begin
          link_frame_o <= 1'b0;
          link_data_o <= 1'b0;
          tx_r <= TX_IDLE;
        end else begin
          link_data_o <= tx_sh_r[WORD_BITS-1];
          tx_sh_r <= {tx_sh_r[WORD_BITS-2:0], 1'b0};
          tx_cnt_r <= tx_cnt_r + 1'b1;
        end
        default: tx_r <= TX_IDLE;
      endcase
    end
  end

  assign range_sel_o = range_r;
  assign flip_en_o = flip_r;

  // helper: cycles of the current frame
  logic [9:0] frame_cyc_r;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) frame_cyc_r <= '0;
    else frame_cyc_r <= link_frame_o ? frame_cyc_r + 1'b1 : '0;
  end

  a_tick_start: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    tick && cap_r == CAP_IDLE |=> adc_start_o ##1 !adc_start_o)
    else $error("conversion not started on sample tick");
  a_tick_period: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    tick |=> tick_cnt_r == $bits(tick_cnt_r)'(SAMPLE_CYCLES - 1))
    else $error("sample timer reload wrong");
  a_bit_spacing: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    bit_en |=> !bit_en [*8] ##1 !bit_en ##1 bit_en)
    else $error("bit enable not every ten cycles");
  a_frame_length: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(link_frame_o) |-> $past(frame_cyc_r) == 10'(FRAME_CYC - 1))
    else $error("frame not forty bits long");
  a_auto_up: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    go_up && !cmd_done |=> range_r == $past(range_r) + 1'b1)
    else $error("range did not step up");
  a_hold_stable: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !auto_r && !cmd_done |=> $stable(range_r))
    else $error("held range moved");
  a_cmd_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cmd_done && cmd.op == OP_HOLD |=> !auto_r && range_r == $past(cmd.arg))
    else $error("hold command not applied");
  a_range_tag: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    take |=> word_r.range == $past(range_r) && word_r.x == $past(adc_x_i))
    else $error("sample word lost range or code");
  a_range_limit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    range_r == RANGE_MAX && !cmd_done |=> range_r >= RANGE_MAX - 1'b1)
    else $error("range jumped from the top");
endmodule : field_readout
`default_nettype wire

// >>> testbench/proc_model.sv
// processor model: link receiver and command word sender
`timescale 1ns/1ns
`default_nettype none
module proc_model
  import field_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic link_data_i,
  input wire logic link_frame_i,
  output logic cmd_clk_o,
  output logic cmd_data_o,
  output logic cmd_frame_o,
  output logic rx_valid_o,
  output logic [WORD_BITS-1:0] rx_word_o,
  output logic [15:0] rx_len_o,
  output logic idle_bad_o,
  output logic avg_valid_o,
  output logic [ADC_W-1:0] avg_x_o,
  output logic [5:0] avg_diff_o,
  output logic avg_full_o
);
  logic [15:0] cnt = 16'h0000;
  sample_word_t rx_s;
  logic [13:0] acc_r = 14'h0000;
  logic [13:0] sum_w;
  logic [ADC_W-1:0] prev_r = 12'h000;
  logic [1:0] n_in = 2'h0;
  logic [4:0] n_avg = 5'h00;
  assign rx_s = rx_word_o;
  assign sum_w = acc_r + {{2{rx_s.x[ADC_W-1]}}, rx_s.x};
  // six-bit signed difference, clipped at both ends
  function automatic logic [5:0] clip6(input logic signed [12:0] d);
    if (d > 13'sh001f) clip6 = 6'h1f;
    else if (d < -13'sh0020) clip6 = 6'h20;
    else clip6 = d[5:0];
  endfunction : clip6
  initial begin
    cmd_clk_o = 1'b0;
    cmd_data_o = 1'b1;
    cmd_frame_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_word_o = '0;
    rx_len_o = 16'h0000;
    idle_bad_o = 1'b0;
    avg_valid_o = 1'b0;
    avg_x_o = '0;
    avg_diff_o = '0;
    avg_full_o = 1'b0;
  end
  // no stall: every word is taken mid-bit as it arrives
  always @(posedge clk_sys_i) begin
    rx_valid_o <= 1'b0;
    avg_valid_o <= 1'b0;
    if (link_frame_i) begin
      cnt <= cnt + 16'h0001;
      if (cnt % BIT_CYC == 5) begin
        rx_word_o <= {rx_word_o[WORD_BITS-2:0], link_data_i};
      end
    end else begin
      if (cnt != 16'h0000) begin
        rx_valid_o <= 1'b1;
        // four 32 Hz vectors make one 8 Hz average (x axis kept here)
        acc_r <= (n_in == 2'h3) ? 14'h0000 : sum_w;
        n_in <= n_in + 2'h1;
        if (n_in == 2'h3) begin
          // 6-bit difference, full vector every 32 averages (4 s)
          avg_valid_o <= 1'b1;
          avg_x_o <= sum_w[13:2];
          avg_diff_o <= clip6({sum_w[13], sum_w[13:2]} - {prev_r[11], prev_r});
          avg_full_o <= (n_avg == 5'h00);
          prev_r <= sum_w[13:2];
          n_avg <= n_avg + 5'h01;
        end
      end
      rx_len_o <= cnt;
      cnt <= 16'h0000;
      if (link_data_i) idle_bad_o <= 1'b1;
    end
  end
  // serial command, msb first; nbits below 12 is a deliberate refusal
  task automatic send_cmd(input logic [CMD_W-1:0] w, input int nbits);
    cmd_frame_o = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    for (int i = nbits - 1; i >= 0; i--) begin
      cmd_data_o = (i < CMD_W) ? w[i] : 1'b0;
      repeat (4) @(negedge clk_sys_i);
      cmd_clk_o = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      cmd_clk_o = 1'b0;
    end
    repeat (4) @(negedge clk_sys_i);
    cmd_frame_o = 1'b0;
    cmd_data_o = ~cmd_data_o;
    repeat (8) @(negedge clk_sys_i);
  endtask : send_cmd
endmodule : proc_model
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the field sensor readout
`timescale 1ns/1ns
`default_nettype none
module testbench
  import field_pkg::*;
;
  localparam int SAMP = 600;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic adc_done_i = 1'b0;
  logic [ADC_W-1:0] adc_x_i = '0, adc_y_i = '0, adc_z_i = '0;
  logic adc_start_o, flip_en_o, link_data_o, link_frame_o;
  logic [RANGE_W-1:0] range_sel_o, r0;
  logic cmd_clk, cmd_data, cmd_frame, rx_valid, idle_bad;
  logic [WORD_BITS-1:0] rx_word;
  logic [15:0] rx_len;
  logic avg_valid, avg_full;
  logic [ADC_W-1:0] avg_x, avg_e, prev_e = 12'h000;
  logic [5:0] avg_diff;
  logic [13:0] sum_e = 14'h0000;
  logic [12:0] d_e;
  int n_e = 0, n_blk = 0;
  sample_word_t got_w;
  logic [31:0] lfsr = 32'h3b81;
  sample_word_t exp_q[$];
  sample_word_t exp_w;
  int err_total = 0, n_checks = 0, n_samples = 0, mode = 0;
  int cyc = 0, last_start = 0;
  logic auto_on = 1'b1;

  field_readout #(.SAMPLE_CYCLES(SAMP)) dut (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .adc_start_o(adc_start_o), .adc_done_i(adc_done_i),
    .adc_x_i(adc_x_i), .adc_y_i(adc_y_i), .adc_z_i(adc_z_i),
    .range_sel_o(range_sel_o), .flip_en_o(flip_en_o), .cmd_clk_i(cmd_clk),
    .cmd_data_i(cmd_data), .cmd_frame_i(cmd_frame),
    .link_data_o(link_data_o), .link_frame_o(link_frame_o));
  proc_model proc (.clk_sys_i(clk_sys_i), .link_data_i(link_data_o),
    .link_frame_i(link_frame_o), .cmd_clk_o(cmd_clk), .cmd_data_o(cmd_data),
    .cmd_frame_o(cmd_frame), .rx_valid_o(rx_valid), .rx_word_o(rx_word),
    .rx_len_o(rx_len), .idle_bad_o(idle_bad), .avg_valid_o(avg_valid),
    .avg_x_o(avg_x), .avg_diff_o(avg_diff), .avg_full_o(avg_full));

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) cyc <= cyc + 1;

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  function automatic logic [ADC_W-1:0] code(input int m);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    if (m == 0) code = {{4{lfsr[8]}}, lfsr[7:0]};
    else if (m == 1) code = 12'h07c1 + {6'h00, lfsr[5:0]};
    else code = lfsr[11:0];
  endfunction : code
  function automatic logic [ADC_W-1:0] amag(input logic [ADC_W-1:0] v);
    amag = v[ADC_W-1] ? (~v + 12'h001) : v;
  endfunction : amag
  function automatic logic [5:0] clip_e(input logic signed [12:0] d);
    if (d > 13'sh001f) clip_e = 6'h1f;
    else if (d < -13'sh0020) clip_e = 6'h20;
    else clip_e = d[5:0];
  endfunction : clip_e
  // expected range after one sample, worked out independently
  function automatic logic [RANGE_W-1:0] nxt(input sample_word_t s);
    logic up, dn;
    up = amag(s.x) > UP_LEVEL || amag(s.y) > UP_LEVEL || amag(s.z) > UP_LEVEL;
    dn = amag(s.x) < DOWN_LEVEL && amag(s.y) < DOWN_LEVEL;
    dn = dn && amag(s.z) < DOWN_LEVEL;
    nxt = s.range;
    if (auto_on && up && s.range != RANGE_MAX) nxt = s.range + 3'h1;
    else if (auto_on && dn && s.range != RANGE_MIN) nxt = s.range - 3'h1;
  endfunction : nxt

  // converter model: answers each start, notes the expected word
  initial begin
    forever begin
      for (int i = 0; i < 2 * SAMP && adc_start_o !== 1'b1; i++) begin
        @(posedge clk_sys_i);
      end
      check(adc_start_o === 1'b1, "start wait");
      if (last_start != 0) check(cyc - last_start == SAMP, "period");
      last_start = cyc;
      repeat (3) @(negedge clk_sys_i);
      adc_x_i = code(mode);
      adc_y_i = code(mode);
      adc_z_i = code(mode);
      adc_done_i = 1'b1;
      r0 = range_sel_o;
      exp_w = {flip_en_o, r0, adc_x_i, adc_y_i, adc_z_i};
      exp_q.push_back(exp_w);
      @(negedge clk_sys_i);
      adc_done_i = 1'b0;
      adc_x_i = ~adc_x_i;
      adc_y_i = ~adc_y_i;
      adc_z_i = ~adc_z_i;
      n_samples++;
      repeat (5) @(negedge clk_sys_i);
      check(range_sel_o === nxt(exp_w), "range step");
    end
  end
  // link side: oldest note against each received word
  always @(posedge clk_sys_i) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "word without sample");
      else begin
        got_w = exp_q.pop_front();
        check(rx_word === got_w, "link word");
        sum_e = sum_e + {{2{got_w.x[ADC_W-1]}}, got_w.x};
        n_e++;
      end
      check(rx_len === 16'(FRAME_CYC), "frame length");
      if (n_e == 4) begin
        avg_e = sum_e[13:2];
        check(avg_valid === 1'b1 && avg_x === avg_e, "average");
        d_e = {avg_e[11], avg_e} - {prev_e[11], prev_e};
        check(avg_diff === clip_e(d_e), "difference");
        check(avg_full === (n_blk == 0), "full vector");
        prev_e = avg_e;
        sum_e = 14'h0000;
        n_e = 0;
        n_blk = (n_blk + 1) % 32;
      end
    end
  end
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    check(1'b0, "timeout");
    stop_test();
  end

  task automatic wait_samples(input int n);
    int t;
    t = n_samples + n;
    for (int i = 0; i < 2 * n * SAMP && n_samples < t; i++) begin
      @(negedge clk_sys_i);
    end
    check(n_samples >= t, "sample wait");
  endtask : wait_samples

  initial begin
    repeat (20) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    check(range_sel_o === RANGE_RST && flip_en_o === 1'b0, "reset");
    wait_samples(9);
    check(range_sel_o === RANGE_MIN, "auto down");
    mode = 1;
    wait_samples(3);
    $display("test auto ranging done");
    proc.send_cmd({OP_HOLD, 5'h00, 3'h2}, 12);
    auto_on = 1'b0;
    check(range_sel_o === 3'h2, "hold range");
    wait_samples(2);
    proc.send_cmd({OP_HOLD, 5'h00, 3'h5}, 11);
    check(range_sel_o === 3'h2, "short word ignored");
    proc.send_cmd({OP_HOLD, 5'h00, 3'h5}, 13);
    check(range_sel_o === 3'h2, "long word ignored");
    proc.send_cmd({OP_FLIP, 5'h00, 3'h1}, 12);
    check(flip_en_o === 1'b1, "flip on");
    wait_samples(2);
    $display("test commands done");
    proc.send_cmd({OP_AUTO, 5'h00, 3'h0}, 12);
    auto_on = 1'b1;
    proc.send_cmd({OP_FLIP, 5'h00, 3'h0}, 12);
    check(flip_en_o === 1'b0, "flip off");
    mode = 2;
    wait_samples(4);
    for (int i = 0; i < 1000 && exp_q.size() != 0; i++) @(negedge clk_sys_i);
    check(exp_q.size() == 0, "words drained");
    check(idle_bad === 1'b0, "idle data low");
    $display("test random stream done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
